// File: adaptive_hs_pwm_gate_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - Active freewheel: protection interval, low-side discharged first
// - Then high-side precharge with adaptive code
// - Charge at setting, measure turn-on, end at high threshold
// - Postcharge ramps code per cycle up to maximum, ends at filter end
// - Adapt only in the two adaptive modes
// - Codes clamped between lowest step and maximum
// - Enable sets precharge code to min(init, max)
// - No filter: raise if slow, lower if fast
// - Step size one or two by step bit
// - Filter: change only on two agreeing cycles
// - Active freewheel: turn-off delayed by freewheel protection
// - Then predischarge with adaptive code for duration
// - Discharge at setting, measure, end at protection expiry
// - Low-side off during protection, then freewheel charge
// - Enable sets predischarge code to min(init, max)
// - No filter: predischarge raise if slow, lower fast
// - Filter: predischarge changes on two agreeing cycles
// - Passive freewheel: low-side always off
// - Passive: no protection at rising edge
// - Passive: no protection at falling edge
// - PWM input synchronised by two flip-flops
// - Protection and blank times come from ports
module adaptive_hs_pwm_gate_sequencer
    import hs_pwm_seq_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic pwm_input_i,
    input wire logic switch_node_high_i,
    input wire logic switch_node_low_i,
    input wire logic active_freewheel_enable_i,
    input wire logic [1:0] adaptive_gate_mode_i,
    input wire logic adapt_filter_enable_i,
    input wire logic adapt_step_double_i,
    input wire logic bridge_pwm_enable_i,
    input wire logic bridge_pwm_enable_write_i,
    input wire logic [5:0] charge_current_setting_i,
    input wire logic [5:0] discharge_current_setting_i,
    input wire logic [5:0] freewheel_gate_current_i,
    input wire logic [5:0] max_gate_current_i,
    input wire logic [5:0] precharge_initial_value_i,
    input wire logic [5:0] predischarge_initial_value_i,
    input wire logic [7:0] freewheel_protection_time_i,
    input wire logic [7:0] active_protection_time_i,
    input wire logic [7:0] drain_source_filter_time_i,
    input wire logic [7:0] precharge_duration_i,
    input wire logic [7:0] predischarge_duration_i,
    input wire logic [7:0] turn_on_target_i,
    input wire logic [7:0] turn_off_target_i,
    output logic hs_charge_en_o,
    output logic hs_discharge_en_o,
    output logic [5:0] hs_current_code_o,
    output logic ls_charge_en_o,
    output logic ls_discharge_en_o,
    output logic [5:0] ls_current_code_o,
    output logic [5:0] precharge_current_code_o,
    output logic [5:0] predischarge_current_code_o,
    output logic [7:0] turn_on_delay_o,
    output logic [7:0] turn_off_delay_o,
    output logic delay_update_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser
    logic pwm_meta_reg;
    logic pwm_sync_reg;
    logic pwm_prev_reg;
    logic sh_high_meta_reg;
    logic sh_high_reg;
    logic sh_low_meta_reg;
    logic sh_low_reg;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pwm_meta_reg <= 1'b0;
            pwm_sync_reg <= 1'b0;
            pwm_prev_reg <= 1'b0;
            sh_high_meta_reg <= 1'b0;
            sh_high_reg <= 1'b0;
            sh_low_meta_reg <= 1'b0;
            sh_low_reg <= 1'b0;
        end else begin
            pwm_meta_reg <= pwm_input_i;
            pwm_sync_reg <= pwm_meta_reg;
            pwm_prev_reg <= pwm_sync_reg;
            sh_high_meta_reg <= switch_node_high_i;
            sh_high_reg <= sh_high_meta_reg;
            sh_low_meta_reg <= switch_node_low_i;
            sh_low_reg <= sh_low_meta_reg;
        end
    end

    logic pwm_rise;
    logic pwm_fall;
    assign pwm_rise = pwm_sync_reg & ~pwm_prev_reg;
    assign pwm_fall = ~pwm_sync_reg & pwm_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    seq_state_t state_reg, state_next;
    logic [7:0] timer_reg, timer_next;
    logic [7:0] timer2_reg, timer2_next;
    logic [7:0] dly_reg, dly_next;
    logic [5:0] ramp_reg, ramp_next;
    logic [7:0] ton_reg, ton_next;
    logic [7:0] toff_reg, toff_next;
    logic on_done_reg, on_done_next;
    logic off_done_reg, off_done_next;
    logic [5:0] pchg_reg, pchg_next;
    logic [5:0] pdchg_reg, pdchg_next;

    // Abort on an opposite edge mid-sequence so the bridge follows PWM
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        timer2_next = timer2_reg;
        dly_next = dly_reg;
        ramp_next = ramp_reg;
        ton_next = ton_reg;
        toff_next = toff_reg;
        on_done_next = 1'b0;
        off_done_next = 1'b0;
        if (timer_reg != TIMER_RESET) timer_next = timer_reg - 8'h01;
        if (timer2_reg != TIMER_RESET) timer2_next = timer2_reg - 8'h01;
        // Turn-off count freezes at the low threshold, read at expiry
        if (dly_reg != DELAY_SAT &&
            !(sh_low_reg && (state_reg == ST_PREDCHG ||
                             state_reg == ST_DISCHG))) begin
            dly_next = dly_reg + 8'h01;
        end
        if (pwm_rise) begin
            dly_next = DELAY_RESET;
            if (active_freewheel_enable_i) begin
                state_next = ST_ON_PROT;
                timer_next = freewheel_protection_time_i;
            end else begin
                state_next = ST_PRECHG;
                timer_next = precharge_duration_i;
            end
        end else if (pwm_fall) begin
            dly_next = DELAY_RESET;
            if (active_freewheel_enable_i) begin
                state_next = ST_SYMM;
                timer_next = freewheel_protection_time_i;
            end else begin
                state_next = ST_PREDCHG;
                timer_next = predischarge_duration_i;
                timer2_next = active_protection_time_i;
            end
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_ON: begin
                end
                ST_ON_PROT: begin
                    if (timer_reg == TIMER_RESET) begin
                        state_next = ST_PRECHG;
                        timer_next = precharge_duration_i;
                    end
                end
                ST_PRECHG: begin
                    if (timer_reg == TIMER_RESET) state_next = ST_CHARGE;
                end
                ST_CHARGE: begin
                    if (sh_high_reg) begin
                        state_next = ST_POSTCHG;
                        ton_next = dly_reg;
                        on_done_next = 1'b1;
                        ramp_next = charge_current_setting_i;
                        timer_next = drain_source_filter_time_i;
                    end
                end
                ST_POSTCHG: begin
                    if (ramp_reg < max_gate_current_i) begin
                        ramp_next = ramp_reg + 6'h01;
                    end
                    if (timer_reg == TIMER_RESET) state_next = ST_ON;
                end
                ST_SYMM: begin
                    if (timer_reg == TIMER_RESET) begin
                        state_next = ST_PREDCHG;
                        timer_next = predischarge_duration_i;
                        timer2_next = active_protection_time_i;
                        dly_next = DELAY_RESET;
                    end
                end
                ST_PREDCHG: begin
                    if (timer_reg == TIMER_RESET) state_next = ST_DISCHG;
                end
                ST_DISCHG: begin
                    if (timer2_reg == TIMER_RESET) begin
                        toff_next = dly_reg;
                        off_done_next = 1'b1;
                        state_next = ST_FW_CHG;
                        timer_next = drain_source_filter_time_i;
                    end
                end
                ST_FW_CHG: begin
                    if (timer_reg == TIMER_RESET) state_next = ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Current code adaptation
    logic adapt_on;
    logic [5:0] step;
    logic on_slow_reg, on_slow_next;
    logic on_fast_reg, on_fast_next;
    logic off_slow_reg, off_slow_next;
    logic off_fast_reg, off_fast_next;

    // Adaptive mode gates self-adjustment
    assign adapt_on = (adaptive_gate_mode_i == MODE_ADAPT_A) ||
                      (adaptive_gate_mode_i == MODE_ADAPT_B);
    assign step = {4'h0, adapt_step_double_i ? STEP_DOUBLE
                                             : STEP_SINGLE};

    function automatic logic [5:0] adapt_code(
        input logic [5:0] code,
        input logic slow,
        input logic fast,
        input logic slow_prev,
        input logic fast_prev,
        input logic filt,
        input logic [5:0] stp,
        input logic [5:0] maxc
    );
        logic up;
        logic down;
        logic [6:0] sum;
        logic [5:0] res;
        up = filt ? (slow & slow_prev) : slow;
        down = filt ? (fast & fast_prev) : fast;
        sum = {1'b0, code} + {1'b0, stp};
        res = code;
        if (up) res = (sum > {1'b0, maxc}) ? maxc : sum[5:0];
        if (down) res = (code < stp) ? CODE_MIN : code - stp;
        if (res > maxc) res = maxc;
        return res;
    endfunction : adapt_code

    always_comb begin
        pchg_next = pchg_reg;
        pdchg_next = pdchg_reg;
        on_slow_next = on_slow_reg;
        on_fast_next = on_fast_reg;
        off_slow_next = off_slow_reg;
        off_fast_next = off_fast_reg;
        if (bridge_pwm_enable_write_i && bridge_pwm_enable_i) begin
            pchg_next = (precharge_initial_value_i < max_gate_current_i)
                ? precharge_initial_value_i : max_gate_current_i;
            pdchg_next = (predischarge_initial_value_i < max_gate_current_i)
                ? predischarge_initial_value_i
                : max_gate_current_i;
        end else begin
            if (on_done_reg) begin
                on_slow_next = ton_reg > turn_on_target_i;
                on_fast_next = ton_reg < turn_on_target_i;
                if (adapt_on) begin
                    pchg_next = adapt_code(pchg_reg, on_slow_next,
                        on_fast_next, on_slow_reg, on_fast_reg,
                        adapt_filter_enable_i, step, max_gate_current_i);
                end
            end
            if (off_done_reg) begin
                off_slow_next = toff_reg > turn_off_target_i;
                off_fast_next = toff_reg < turn_off_target_i;
                if (adapt_on) begin
                    pdchg_next = adapt_code(pdchg_reg, off_slow_next,
                        off_fast_next, off_slow_reg, off_fast_reg,
                        adapt_filter_enable_i, step, max_gate_current_i);
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            timer_reg <= TIMER_RESET;
            timer2_reg <= TIMER_RESET;
            dly_reg <= DELAY_RESET;
            ramp_reg <= CODE_RESET;
            ton_reg <= DELAY_RESET;
            toff_reg <= DELAY_RESET;
            on_done_reg <= 1'b0;
            off_done_reg <= 1'b0;
            pchg_reg <= CODE_RESET;
            pdchg_reg <= CODE_RESET;
            on_slow_reg <= 1'b0;
            on_fast_reg <= 1'b0;
            off_slow_reg <= 1'b0;
            off_fast_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            timer2_reg <= timer2_next;
            dly_reg <= dly_next;
            ramp_reg <= ramp_next;
            ton_reg <= ton_next;
            toff_reg <= toff_next;
            on_done_reg <= on_done_next;
            off_done_reg <= off_done_next;
            pchg_reg <= pchg_next;
            pdchg_reg <= pdchg_next;
            on_slow_reg <= on_slow_next;
            on_fast_reg <= on_fast_next;
            off_slow_reg <= off_slow_next;
            off_fast_reg <= off_fast_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate drive outputs
    logic afw;
    assign afw = active_freewheel_enable_i;

    always_comb begin
        hs_charge_en_o = 1'b0;
        hs_discharge_en_o = 1'b0;
        hs_current_code_o = CODE_RESET;
        ls_charge_en_o = 1'b0;
        ls_discharge_en_o = 1'b0;
        ls_current_code_o = CODE_RESET;
        unique case (state_reg)
            ST_ON_PROT: begin
                ls_discharge_en_o = afw;
                ls_current_code_o = freewheel_gate_current_i;
            end
            ST_PRECHG: begin
                hs_charge_en_o = 1'b1;
                hs_current_code_o = pchg_reg;
            end
            ST_CHARGE: begin
                hs_charge_en_o = 1'b1;
                hs_current_code_o = charge_current_setting_i;
            end
            ST_POSTCHG, ST_ON: begin
                hs_charge_en_o = 1'b1;
                hs_current_code_o = (state_reg == ST_ON)
                    ? max_gate_current_i : ramp_reg;
            end
            ST_PREDCHG: begin
                hs_discharge_en_o = 1'b1;
                hs_current_code_o = pdchg_reg;
            end
            ST_DISCHG: begin
                hs_discharge_en_o = 1'b1;
                hs_current_code_o = discharge_current_setting_i;
            end
            ST_FW_CHG: begin
                // Passive freewheel never turns the low side on
                ls_charge_en_o = afw & sh_low_reg;
                ls_current_code_o = freewheel_gate_current_i;
            end
            ST_IDLE, ST_SYMM: begin
            end
        endcase
    end

    assign precharge_current_code_o = pchg_reg;
    assign predischarge_current_code_o = pdchg_reg;
    assign turn_on_delay_o = ton_reg;
    assign turn_off_delay_o = toff_reg;
    assign delay_update_o = on_done_reg | off_done_reg;

endmodule : adaptive_hs_pwm_gate_sequencer

// File: adaptive_hs_pwm_gate_sequencer_bench.sv
`timescale 1ns/1ps
module adaptive_hs_pwm_gate_sequencer_bench;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic pwm = 1'b0, afw = 1'b1, filt = 1'b0, dbl = 1'b0;
    logic en_val = 1'b1, en_wr = 1'b0;
    logic [1:0] mode = 2'h2;
    logic [5:0] chg = 6'h03, dchg = 6'h03, fwc = 6'h08, maxc = 6'h0c;
    logic [5:0] pre_init = 6'h14, pd_init = 6'h05;
    logic [7:0] fw_t = 8'h04, ac_t = 8'h14, flt_t = 8'h50;
    logic [7:0] pc_t = 8'h06, pd_t = 8'h06;
    logic [7:0] t_on = 8'h00, t_off = 8'h00;
    logic sw_high, sw_low, hs_chg, hs_dis, ls_chg, ls_dis, upd;
    logic [5:0] hs_code, pre_code, pd_code, peak, ls_code;
    logic [7:0] on_dly, off_dly;
    int err_total = 0;
    int cmp_count = 0;
    int lsd_cnt;
    int upd_cnt;

    initial forever #12.5 clk_sys_i = ~clk_sys_i;

    adaptive_hs_pwm_gate_sequencer dut (
        .clk_sys_i, .reset_i, .pwm_input_i(pwm),
        .switch_node_high_i(sw_high), .switch_node_low_i(sw_low),
        .active_freewheel_enable_i(afw), .adaptive_gate_mode_i(mode),
        .adapt_filter_enable_i(filt), .adapt_step_double_i(dbl),
        .bridge_pwm_enable_i(en_val), .bridge_pwm_enable_write_i(en_wr),
        .charge_current_setting_i(chg), .discharge_current_setting_i(dchg),
        .freewheel_gate_current_i(fwc), .max_gate_current_i(maxc),
        .precharge_initial_value_i(pre_init),
        .predischarge_initial_value_i(pd_init),
        .freewheel_protection_time_i(fw_t), .active_protection_time_i(ac_t),
        .drain_source_filter_time_i(flt_t), .precharge_duration_i(pc_t),
        .predischarge_duration_i(pd_t), .turn_on_target_i(t_on),
        .turn_off_target_i(t_off), .hs_charge_en_o(hs_chg),
        .hs_discharge_en_o(hs_dis), .hs_current_code_o(hs_code),
        .ls_charge_en_o(ls_chg), .ls_discharge_en_o(ls_dis),
        .ls_current_code_o(ls_code), .precharge_current_code_o(pre_code),
        .predischarge_current_code_o(pd_code), .turn_on_delay_o(on_dly),
        .turn_off_delay_o(off_dly), .delay_update_o(upd)
    );

    half_bridge_model bridge (
        .clk_sys_i, .hs_charge_en_i(hs_chg), .hs_discharge_en_i(hs_dis),
        .rise_cycles_i(8'h0a), .fall_cycles_i(8'h08),
        .node_high_o(sw_high), .node_low_o(sw_low)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %0d exp %0d", $time, msg,
                     got, exp);
        end
    endtask : chk

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // Fixed windows: every phase of this setup ends well inside 150 cycles
    task automatic pwm_cycle();
        lsd_cnt = 0;
        upd_cnt = 0;
        peak = 6'h00;
        @(negedge clk_sys_i) pwm = 1'b1;
        repeat (150) begin
            @(negedge clk_sys_i);
            if (ls_dis === 1'b1 && ls_code === fwc) lsd_cnt++;
            if (upd === 1'b1) upd_cnt++;
            if (sw_high === 1'b1 && hs_chg === 1'b1 && hs_code > peak) begin
                peak = hs_code;
            end
        end
        pwm = 1'b0;
        repeat (150) begin
            @(negedge clk_sys_i);
            if (upd === 1'b1) upd_cnt++;
        end
    endtask : pwm_cycle

    task automatic en_load();
        @(negedge clk_sys_i) en_wr = 1'b1;
        @(negedge clk_sys_i) en_wr = 1'b0;
        @(negedge clk_sys_i);
    endtask : en_load
    ////////////////////////////////////////////////////////////////////////
    task automatic t_load_up();
        en_load();
        chk(8'(pre_code), 8'h0c, "pre init");
        chk(8'(pd_code), 8'h05, "pd init");
        pwm_cycle();
        chk(8'(lsd_cnt), 8'h05, "protect len");
        chk(8'(peak), 8'h0c, "ramp top");
        chk(8'(pre_code), 8'h0c, "pre top clamp");
        chk(8'(pd_code), 8'h06, "pd up one");
        chk(on_dly, 8'h11, "on delay");
        chk(off_dly, 8'h0a, "off delay");
        chk(8'(upd_cnt), 8'h02, "update pulses");
        dbl = 1'b1;
        pwm_cycle();
        chk(8'(pd_code), 8'h08, "pd up two");
        $display("test load_up done");
    endtask : t_load_up

    task automatic t_down_equal();
        t_on = 8'hff;
        t_off = 8'hff;
        pwm_cycle();
        chk(8'(pre_code), 8'h0a, "pre down two");
        chk(8'(pd_code), 8'h06, "pd down two");
        t_on = 8'h11;
        t_off = 8'h0a;
        pwm_cycle();
        chk(8'(pre_code), 8'h0a, "pre equal");
        chk(8'(pd_code), 8'h06, "pd equal");
        t_on = 8'hff;
        t_off = 8'hff;
        pd_init = 6'h01;
        en_load();
        pwm_cycle();
        chk(8'(pd_code), 8'h00, "pd floor");
        $display("test down_equal done");
    endtask : t_down_equal

    task automatic t_filter();
        filt = 1'b1;
        dbl = 1'b0;
        pd_init = 6'h05;
        en_load();
        t_on = 8'h00;
        t_off = 8'h00;
        pwm_cycle();
        chk(8'(pd_code), 8'h05, "pd first hold");
        t_on = 8'hff;
        t_off = 8'hff;
        pwm_cycle();
        chk(8'(pre_code), 8'h0c, "pre hold");
        chk(8'(pd_code), 8'h05, "pd hold");
        pwm_cycle();
        chk(8'(pre_code), 8'h0b, "pre agreed");
        chk(8'(pd_code), 8'h04, "pd agreed");
        $display("test filter done");
    endtask : t_filter

    task automatic t_modes();
        filt = 1'b0;
        t_off = 8'h00;
        for (int m = 0; m < 2; m++) begin
            mode = 2'(m);
            en_load();
            pwm_cycle();
            chk(8'(pre_code), 8'h0c, "fixed pre");
            chk(8'(pd_code), 8'h05, "fixed pd");
        end
        mode = 2'h3;
        pwm_cycle();
        chk(8'(pre_code), 8'h0b, "mode b pre");
        chk(8'(pd_code), 8'h06, "mode b pd");
        $display("test modes done");
    endtask : t_modes

    task automatic t_passive();
        afw = 1'b0;
        pwm_cycle();
        chk(8'(lsd_cnt), 8'h00, "no low side");
        chk(8'(peak), 8'h0c, "passive ramp");
        chk(8'(pd_code), 8'h07, "passive pd");
        chk(8'(pre_code), 8'h0a, "passive pre");
        en_val = 1'b0;
        en_load();
        chk(8'(pre_code), 8'h0a, "clear no load");
        chk(8'(pd_code), 8'h07, "clear no pd load");
        $display("test passive done");
    endtask : t_passive
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i) reset_i = 1'b0;
        chk(8'(pre_code), 8'h00, "reset pre");
        chk(8'(pd_code), 8'h00, "reset pd");
        t_load_up();
        t_down_equal();
        t_filter();
        t_modes();
        t_passive();
        results();
    end

    initial begin
        #1ms;
        err_total++;
        $display("mismatch at %0t: run limit", $time);
        results();
    end
endmodule : adaptive_hs_pwm_gate_sequencer_bench

// File: half_bridge_model.sv
`timescale 1ns/1ps
module half_bridge_model (
    input wire logic clk_sys_i,
    input wire logic hs_charge_en_i,
    input wire logic hs_discharge_en_i,
    input wire logic [7:0] rise_cycles_i,
    input wire logic [7:0] fall_cycles_i,
    output logic node_high_o,
    output logic node_low_o
);
    int up_cnt = 0;
    int dn_cnt = 0;
    // Gate charge time, not current, sets the crossing; keeps delays fixed
    always @(posedge clk_sys_i) begin
        if (hs_charge_en_i) begin
            up_cnt <= up_cnt + 1;
            dn_cnt <= 0;
        end else if (hs_discharge_en_i) begin
            dn_cnt <= dn_cnt + 1;
            up_cnt <= 0;
        end
    end
    assign node_high_o = up_cnt >= int'(rise_cycles_i);
    assign node_low_o = dn_cnt >= int'(fall_cycles_i);
endmodule : half_bridge_model

// File: hs_pwm_seq_monitor.sv
`timescale 1ns/1ps
module hs_pwm_seq_monitor (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic pwm_input_i,
    input wire logic active_freewheel_enable_i,
    input wire logic [1:0] adaptive_gate_mode_i,
    input wire logic bridge_pwm_enable_write_i,
    input wire logic hs_charge_en_o,
    input wire logic hs_discharge_en_o,
    input wire logic [5:0] hs_current_code_o,
    input wire logic ls_charge_en_o,
    input wire logic ls_discharge_en_o,
    input wire logic [5:0] precharge_current_code_o,
    input wire logic [5:0] predischarge_current_code_o,
    input wire logic delay_update_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////
    passive_ls_off_a: assert property (
        !active_freewheel_enable_i |-> !ls_charge_en_o && !ls_discharge_en_o)
        else $error("low side driven in passive mode");
    no_shoot_a: assert property (
        hs_charge_en_o |-> !ls_charge_en_o)
        else $error("both gates charged together");
    on_prot_a: assert property (
        active_freewheel_enable_i && $rose(pwm_input_i)
        |-> ##[2:4] (ls_discharge_en_o && !hs_charge_en_o))
        else $error("no protection phase at rising edge");
    passive_rise_a: assert property (
        !active_freewheel_enable_i && $rose(pwm_input_i)
        |-> ##[2:5] hs_charge_en_o)
        else $error("passive turn-on not immediate");
    passive_fall_a: assert property (
        !active_freewheel_enable_i && $fell(pwm_input_i)
        |-> ##[2:5] hs_discharge_en_o)
        else $error("passive turn-off not immediate");
    symm_delay_a: assert property (
        active_freewheel_enable_i && $fell(pwm_input_i)
        |-> !hs_discharge_en_o [*6])
        else $error("turn-off not delayed");
    pre_code_a: assert property (
        $rose(hs_charge_en_o) && adaptive_gate_mode_i[1]
        |-> hs_current_code_o == precharge_current_code_o)
        else $error("precharge not at adaptive code");
    predis_code_a: assert property (
        $rose(hs_discharge_en_o) && adaptive_gate_mode_i[1]
        |-> hs_current_code_o == predischarge_current_code_o)
        else $error("predischarge not at adaptive code");
    code_cause_a: assert property (
        $changed(precharge_current_code_o)
        |-> $past(delay_update_o) || $past(delay_update_o, 2)
        || $past(bridge_pwm_enable_write_i)
        || $past(bridge_pwm_enable_write_i, 2))
        else $error("code changed without cause");
    mode_hold_a: assert property (
        !adaptive_gate_mode_i[1] && !$past(bridge_pwm_enable_write_i)
        && !$past(bridge_pwm_enable_write_i, 2)
        |-> $stable(predischarge_current_code_o))
        else $error("code adapted in fixed mode");
endmodule : hs_pwm_seq_monitor

bind adaptive_hs_pwm_gate_sequencer hs_pwm_seq_monitor mon (
    .clk_sys_i, .reset_i, .pwm_input_i, .active_freewheel_enable_i,
    .adaptive_gate_mode_i, .bridge_pwm_enable_write_i, .hs_charge_en_o,
    .hs_discharge_en_o, .hs_current_code_o, .ls_charge_en_o,
    .ls_discharge_en_o, .precharge_current_code_o,
    .predischarge_current_code_o, .delay_update_o
);

// File: hs_pwm_seq_pkg.sv
package hs_pwm_seq_pkg;
    localparam int CODE_W = 6;
    localparam int TIME_W = 8;
    localparam int DLY_W = 8;
    // Lowest current step, code 0
    localparam logic [5:0] CODE_MIN = 6'h00;
    localparam logic [5:0] CODE_RESET = 6'h00;
    localparam logic [1:0] STEP_SINGLE = 2'h1;
    localparam logic [1:0] STEP_DOUBLE = 2'h2;
    // Adaptive modes of the gate mode field
    localparam logic [1:0] MODE_ADAPT_A = 2'h2;
    localparam logic [1:0] MODE_ADAPT_B = 2'h3;
    localparam logic [7:0] TIMER_RESET = 8'h00;
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam logic [7:0] DELAY_SAT = 8'hff;

    typedef enum logic [1:0] {
        SRC_OFF,
        SRC_FIXED,
        SRC_ADAPT,
        SRC_RAMP
    } src_sel_t;

    typedef enum {
        ST_IDLE,
        ST_ON_PROT,
        ST_PRECHG,
        ST_CHARGE,
        ST_POSTCHG,
        ST_ON,
        ST_SYMM,
        ST_PREDCHG,
        ST_DISCHG,
        ST_FW_CHG
    } seq_state_t;
endpackage : hs_pwm_seq_pkg
